// ### inc/emcr_map.svh
// Register offsets, field positions and reset values of the calibration bank
`ifndef EMCR_MAP_SVH
`define EMCR_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define EMCR_IDX_MODE_ONE 7'h0b
`define EMCR_IDX_I2_GAIN 7'h1c
`define EMCR_IDX_W_GAIN 7'h1d
`define EMCR_IDX_VAR_GAIN 7'h1e
`define EMCR_IDX_VA_GAIN 7'h1f
`define EMCR_IDX_W_OFS 7'h20
`define EMCR_IDX_VAR_OFS 7'h21
`define EMCR_IDX_IRMS_OFS 7'h22
`define EMCR_IDX_VRMS_OFS 7'h23
`define EMCR_IDX_W_SCALE 7'h24
`define EMCR_IDX_VAR_SCALE 7'h25
`define EMCR_IDX_VA_SCALE 7'h26
`define EMCR_IDX_P1_NUM 7'h27
`define EMCR_IDX_P1_DEN 7'h28
`define EMCR_IDX_P2_NUM 7'h29
`define EMCR_IDX_P2_DEN 7'h2a
`define EMCR_IDX_ZX_MODE 7'h2b
`define EMCR_IDX_RSV_3B 7'h3b
`define EMCR_IDX_RSV_3C 7'h3c
`define EMCR_IDX_CAL_MODE 7'h3d
`define EMCR_IDX_RSV_3E 7'h3e
`define EMCR_IDX_RSV_3F 7'h3f

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define EMCR_BIT_SOFT_RESET 7
`define EMCR_BIT_ZX_FILTER_OFF 6
`define EMCR_BIT_INTEGRATOR_ON 5
`define EMCR_BIT_CHANNEL_SWAP 4
`define EMCR_BIT_ADC_POWER_DOWN 3
`define EMCR_BIT_P2_OFF 2
`define EMCR_BIT_P1_OFF 1
`define EMCR_BIT_HIGHPASS_OFF 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EMCR_RST_MODE_ONE 8'h06
`define EMCR_RST_DEN 16'h003f
`define EMCR_RST_RSV_3C 16'h0300
`define EMCR_RST_ZERO 16'h0000
`define EMCR_RST_ZERO8 8'h00
`define EMCR_RST_ZERO12 12'h000

`endif

// ### inc/emcr_pkg.sv
// Types shared by the calibration register bank
package emcr_pkg;

    typedef enum logic [1:0] {
        EMCR_ST_ADDR,
        EMCR_ST_SRST
    } emcr_state_type;

    // Decoded mode controls handed to the measurement datapath
    typedef struct packed {
        logic zero_cross_filter_off;
        logic integrator_on;
        logic channel_swap;
        logic adc_power_down;
        logic pulse_out_two_off;
        logic pulse_out_one_off;
        logic highpass_off;
    } emcr_mode_type;

    // Calibration values handed to the datapath
    typedef struct packed {
        logic [11:0] second_current_match_gain;
        logic [11:0] active_power_gain;
        logic [11:0] reactive_power_gain;
        logic [11:0] apparent_power_gain;
        logic [15:0] active_power_offset;
        logic [15:0] reactive_power_offset;
        logic [11:0] current_rms_offset;
        logic [11:0] voltage_rms_offset;
        logic [7:0] active_energy_scale;
        logic [7:0] reactive_energy_scale;
        logic [7:0] apparent_energy_scale;
        logic [15:0] pulse_out_one_numerator;
        logic [15:0] pulse_out_one_denominator;
        logic [15:0] pulse_out_two_numerator;
        logic [15:0] pulse_out_two_denominator;
        logic [7:0] zero_cross_output_mode;
        logic [7:0] calibration_mode;
    } emcr_cal_type;

endpackage

// ### core/emcr_regs.sv
// AHB-Lite calibration and mode register bank of the energy measurement core
`timescale 1ns/1ns
`include "emcr_map.svh"

module emcr_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output emcr_pkg::emcr_mode_type mode_ctrl,
    output emcr_pkg::emcr_cal_type cal_ctrl,
    output logic soft_reset_busy
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] mode_one_ff;
    logic [11:0] i2_gain_ff;
    logic [11:0] w_gain_ff;
    logic [11:0] var_gain_ff;
    logic [11:0] va_gain_ff;
    logic [15:0] w_ofs_ff;
    logic [15:0] var_ofs_ff;
    logic [11:0] irms_ofs_ff;
    logic [11:0] vrms_ofs_ff;
    logic [7:0] w_scale_ff;
    logic [7:0] var_scale_ff;
    logic [7:0] va_scale_ff;
    logic [15:0] p1_num_ff;
    logic [15:0] p1_den_ff;
    logic [15:0] p2_num_ff;
    logic [15:0] p2_den_ff;
    logic [7:0] zx_mode_ff;
    logic [7:0] cal_mode_ff;
    logic [15:0] rsv_3b_ff;
    logic [15:0] rsv_3c_ff;
    logic [15:0] rsv_3e_ff;
    logic [15:0] rsv_3f_ff;

    // ------------------------------------------------------------
    // AHB-Lite address phase capture
    // ------------------------------------------------------------
    emcr_pkg::emcr_state_type state_ff;
    emcr_pkg::emcr_state_type nxt_state;
    logic wr_pend_ff;
    logic [6:0] idx_ff;
    logic [31:0] rdata_ff;

    wire addr_take = hsel && hready && htrans[1];
    wire [6:0] addr_idx = haddr[8:2];
    wire wr_now = wr_pend_ff;
    wire [6:0] wr_idx = idx_ff;

    function automatic logic wr_hit(input logic [6:0] idx);
        wr_hit = wr_now && (wr_idx == idx);
    endfunction

    // Soft reset: one write of bit 7 starts a one-cycle sweep of the bank
    wire srst_req = wr_hit(`EMCR_IDX_MODE_ONE) && hwdata[`EMCR_BIT_SOFT_RESET];
    wire srst_now = (state_ff == emcr_pkg::EMCR_ST_SRST);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            emcr_pkg::EMCR_ST_ADDR: begin
                if (srst_req) begin
                    nxt_state = emcr_pkg::EMCR_ST_SRST;
                end
            end
            emcr_pkg::EMCR_ST_SRST: begin
                nxt_state = emcr_pkg::EMCR_ST_ADDR;
            end
            default: begin
                nxt_state = emcr_pkg::EMCR_ST_ADDR;
            end
        endcase
    end

    // Stall during the sweep so no write can race the defaults
    assign hreadyout = !srst_now;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;
    assign soft_reset_busy = srst_now;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= emcr_pkg::EMCR_ST_ADDR;
            wr_pend_ff <= 1'b0;
            idx_ff <= 7'h00;
        end else begin
            state_ff <= nxt_state;
            if (hreadyout) begin
                wr_pend_ff <= addr_take && hwrite;
                idx_ff <= addr_idx;
            end
        end
    end

    // ------------------------------------------------------------
    // Read decode; data registered in the address phase
    // ------------------------------------------------------------
    logic [15:0] rd_mux;

    always_comb begin
        case (addr_idx)
            `EMCR_IDX_MODE_ONE: rd_mux = {8'h00, mode_one_ff};
            `EMCR_IDX_I2_GAIN: rd_mux = {4'h0, i2_gain_ff};
            `EMCR_IDX_W_GAIN: rd_mux = {4'h0, w_gain_ff};
            `EMCR_IDX_VAR_GAIN: rd_mux = {4'h0, var_gain_ff};
            `EMCR_IDX_VA_GAIN: rd_mux = {4'h0, va_gain_ff};
            `EMCR_IDX_W_OFS: rd_mux = w_ofs_ff;
            `EMCR_IDX_VAR_OFS: rd_mux = var_ofs_ff;
            `EMCR_IDX_IRMS_OFS: rd_mux = {4'h0, irms_ofs_ff};
            `EMCR_IDX_VRMS_OFS: rd_mux = {4'h0, vrms_ofs_ff};
            `EMCR_IDX_W_SCALE: rd_mux = {8'h00, w_scale_ff};
            `EMCR_IDX_VAR_SCALE: rd_mux = {8'h00, var_scale_ff};
            `EMCR_IDX_VA_SCALE: rd_mux = {8'h00, va_scale_ff};
            `EMCR_IDX_P1_NUM: rd_mux = p1_num_ff;
            `EMCR_IDX_P1_DEN: rd_mux = p1_den_ff;
            `EMCR_IDX_P2_NUM: rd_mux = p2_num_ff;
            `EMCR_IDX_P2_DEN: rd_mux = p2_den_ff;
            `EMCR_IDX_ZX_MODE: rd_mux = {8'h00, zx_mode_ff};
            `EMCR_IDX_CAL_MODE: rd_mux = {8'h00, cal_mode_ff};
            `EMCR_IDX_RSV_3B: rd_mux = rsv_3b_ff;
            `EMCR_IDX_RSV_3C: rd_mux = rsv_3c_ff;
            `EMCR_IDX_RSV_3E: rd_mux = rsv_3e_ff;
            `EMCR_IDX_RSV_3F: rd_mux = rsv_3f_ff;
            default: rd_mux = 16'h0000;
        endcase
    end

    // Read data captured at the address edge; a write whose data phase
    // shares that cycle is not yet stored, so the read returns the old value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (hreadyout && addr_take && !hwrite) begin
            rdata_ff <= {16'h0000, rd_mux};
        end
    end

    // ------------------------------------------------------------
    // Register writes; soft reset sweep has priority
    // ------------------------------------------------------------
    // Bit 7 is never stored, and a soft reset write drops its other bits
    wire we_mode_one = wr_hit(`EMCR_IDX_MODE_ONE) && !hwdata[`EMCR_BIT_SOFT_RESET];
    wire we_i2_gain = wr_hit(`EMCR_IDX_I2_GAIN);
    wire we_w_gain = wr_hit(`EMCR_IDX_W_GAIN);
    wire we_var_gain = wr_hit(`EMCR_IDX_VAR_GAIN);
    wire we_va_gain = wr_hit(`EMCR_IDX_VA_GAIN);
    wire we_w_ofs = wr_hit(`EMCR_IDX_W_OFS);
    wire we_var_ofs = wr_hit(`EMCR_IDX_VAR_OFS);
    wire we_irms_ofs = wr_hit(`EMCR_IDX_IRMS_OFS);
    wire we_vrms_ofs = wr_hit(`EMCR_IDX_VRMS_OFS);
    wire we_w_scale = wr_hit(`EMCR_IDX_W_SCALE);
    wire we_var_scale = wr_hit(`EMCR_IDX_VAR_SCALE);
    wire we_va_scale = wr_hit(`EMCR_IDX_VA_SCALE);
    wire we_p1_num = wr_hit(`EMCR_IDX_P1_NUM);
    wire we_p1_den = wr_hit(`EMCR_IDX_P1_DEN);
    wire we_p2_num = wr_hit(`EMCR_IDX_P2_NUM);
    wire we_p2_den = wr_hit(`EMCR_IDX_P2_DEN);
    wire we_zx_mode = wr_hit(`EMCR_IDX_ZX_MODE);
    wire we_cal_mode = wr_hit(`EMCR_IDX_CAL_MODE);
    // Reserved words are plain storage so software can restore them
    wire we_rsv_3b = wr_hit(`EMCR_IDX_RSV_3B);
    wire we_rsv_3c = wr_hit(`EMCR_IDX_RSV_3C);
    wire we_rsv_3e = wr_hit(`EMCR_IDX_RSV_3E);
    wire we_rsv_3f = wr_hit(`EMCR_IDX_RSV_3F);

    logic [7:0] nxt_mode_one;
    logic [11:0] nxt_i2_gain;
    logic [11:0] nxt_w_gain;
    logic [11:0] nxt_var_gain;
    logic [11:0] nxt_va_gain;
    logic [15:0] nxt_w_ofs;
    logic [15:0] nxt_var_ofs;
    logic [11:0] nxt_irms_ofs;
    logic [11:0] nxt_vrms_ofs;
    logic [7:0] nxt_w_scale;
    logic [7:0] nxt_var_scale;
    logic [7:0] nxt_va_scale;
    logic [15:0] nxt_p1_num;
    logic [15:0] nxt_p1_den;
    logic [15:0] nxt_p2_num;
    logic [15:0] nxt_p2_den;
    logic [7:0] nxt_zx_mode;
    logic [7:0] nxt_cal_mode;
    logic [15:0] nxt_rsv_3b;
    logic [15:0] nxt_rsv_3c;
    logic [15:0] nxt_rsv_3e;
    logic [15:0] nxt_rsv_3f;

    // Sweep wins; a write stalled behind it lands on the cycle after
    assign nxt_mode_one = srst_now ? `EMCR_RST_MODE_ONE :
        we_mode_one ? {1'b0, hwdata[6:0]} :
        mode_one_ff;

    assign nxt_i2_gain = srst_now ? `EMCR_RST_ZERO12 :
        we_i2_gain ? hwdata[11:0] :
        i2_gain_ff;
    assign nxt_w_gain = srst_now ? `EMCR_RST_ZERO12 :
        we_w_gain ? hwdata[11:0] :
        w_gain_ff;
    assign nxt_var_gain = srst_now ? `EMCR_RST_ZERO12 :
        we_var_gain ? hwdata[11:0] :
        var_gain_ff;
    assign nxt_va_gain = srst_now ? `EMCR_RST_ZERO12 :
        we_va_gain ? hwdata[11:0] :
        va_gain_ff;
    assign nxt_w_ofs = srst_now ? `EMCR_RST_ZERO :
        we_w_ofs ? hwdata[15:0] :
        w_ofs_ff;
    assign nxt_var_ofs = srst_now ? `EMCR_RST_ZERO :
        we_var_ofs ? hwdata[15:0] :
        var_ofs_ff;
    assign nxt_irms_ofs = srst_now ? `EMCR_RST_ZERO12 :
        we_irms_ofs ? hwdata[11:0] :
        irms_ofs_ff;
    assign nxt_vrms_ofs = srst_now ? `EMCR_RST_ZERO12 :
        we_vrms_ofs ? hwdata[11:0] :
        vrms_ofs_ff;
    assign nxt_w_scale = srst_now ? `EMCR_RST_ZERO8 :
        we_w_scale ? hwdata[7:0] :
        w_scale_ff;
    assign nxt_var_scale = srst_now ? `EMCR_RST_ZERO8 :
        we_var_scale ? hwdata[7:0] :
        var_scale_ff;
    assign nxt_va_scale = srst_now ? `EMCR_RST_ZERO8 :
        we_va_scale ? hwdata[7:0] :
        va_scale_ff;
    assign nxt_p1_num = srst_now ? `EMCR_RST_ZERO :
        we_p1_num ? hwdata[15:0] :
        p1_num_ff;
    assign nxt_p1_den = srst_now ? `EMCR_RST_DEN :
        we_p1_den ? hwdata[15:0] :
        p1_den_ff;
    assign nxt_p2_num = srst_now ? `EMCR_RST_ZERO :
        we_p2_num ? hwdata[15:0] :
        p2_num_ff;
    assign nxt_p2_den = srst_now ? `EMCR_RST_DEN :
        we_p2_den ? hwdata[15:0] :
        p2_den_ff;
    assign nxt_zx_mode = srst_now ? `EMCR_RST_ZERO8 :
        we_zx_mode ? hwdata[7:0] :
        zx_mode_ff;
    assign nxt_cal_mode = srst_now ? `EMCR_RST_ZERO8 :
        we_cal_mode ? hwdata[7:0] :
        cal_mode_ff;
    assign nxt_rsv_3b = srst_now ? `EMCR_RST_ZERO :
        we_rsv_3b ? hwdata[15:0] :
        rsv_3b_ff;
    assign nxt_rsv_3c = srst_now ? `EMCR_RST_RSV_3C :
        we_rsv_3c ? hwdata[15:0] :
        rsv_3c_ff;
    assign nxt_rsv_3e = srst_now ? `EMCR_RST_ZERO :
        we_rsv_3e ? hwdata[15:0] :
        rsv_3e_ff;
    assign nxt_rsv_3f = srst_now ? `EMCR_RST_ZERO :
        we_rsv_3f ? hwdata[15:0] :
        rsv_3f_ff;

    // Async reset loads constants only; the sweep goes through the next values
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_one_ff <= `EMCR_RST_MODE_ONE;
            i2_gain_ff <= `EMCR_RST_ZERO12;
            w_gain_ff <= `EMCR_RST_ZERO12;
            var_gain_ff <= `EMCR_RST_ZERO12;
            va_gain_ff <= `EMCR_RST_ZERO12;
            w_ofs_ff <= `EMCR_RST_ZERO;
            var_ofs_ff <= `EMCR_RST_ZERO;
            irms_ofs_ff <= `EMCR_RST_ZERO12;
            vrms_ofs_ff <= `EMCR_RST_ZERO12;
            w_scale_ff <= `EMCR_RST_ZERO8;
            var_scale_ff <= `EMCR_RST_ZERO8;
            va_scale_ff <= `EMCR_RST_ZERO8;
            p1_num_ff <= `EMCR_RST_ZERO;
            p1_den_ff <= `EMCR_RST_DEN;
            p2_num_ff <= `EMCR_RST_ZERO;
            p2_den_ff <= `EMCR_RST_DEN;
            zx_mode_ff <= `EMCR_RST_ZERO8;
            cal_mode_ff <= `EMCR_RST_ZERO8;
            rsv_3b_ff <= `EMCR_RST_ZERO;
            rsv_3c_ff <= `EMCR_RST_RSV_3C;
            rsv_3e_ff <= `EMCR_RST_ZERO;
            rsv_3f_ff <= `EMCR_RST_ZERO;
        end else begin
            mode_one_ff <= nxt_mode_one;
            i2_gain_ff <= nxt_i2_gain;
            w_gain_ff <= nxt_w_gain;
            var_gain_ff <= nxt_var_gain;
            va_gain_ff <= nxt_va_gain;
            w_ofs_ff <= nxt_w_ofs;
            var_ofs_ff <= nxt_var_ofs;
            irms_ofs_ff <= nxt_irms_ofs;
            vrms_ofs_ff <= nxt_vrms_ofs;
            w_scale_ff <= nxt_w_scale;
            var_scale_ff <= nxt_var_scale;
            va_scale_ff <= nxt_va_scale;
            p1_num_ff <= nxt_p1_num;
            p1_den_ff <= nxt_p1_den;
            p2_num_ff <= nxt_p2_num;
            p2_den_ff <= nxt_p2_den;
            zx_mode_ff <= nxt_zx_mode;
            cal_mode_ff <= nxt_cal_mode;
            rsv_3b_ff <= nxt_rsv_3b;
            rsv_3c_ff <= nxt_rsv_3c;
            rsv_3e_ff <= nxt_rsv_3e;
            rsv_3f_ff <= nxt_rsv_3f;
        end
    end

    // ------------------------------------------------------------
    // Controls to the datapath
    // ------------------------------------------------------------
    // A soft reset write with other bits set still sweeps to defaults
    assign mode_ctrl.zero_cross_filter_off = mode_one_ff[`EMCR_BIT_ZX_FILTER_OFF];
    assign mode_ctrl.integrator_on = mode_one_ff[`EMCR_BIT_INTEGRATOR_ON];
    assign mode_ctrl.channel_swap = mode_one_ff[`EMCR_BIT_CHANNEL_SWAP];
    assign mode_ctrl.adc_power_down = mode_one_ff[`EMCR_BIT_ADC_POWER_DOWN];
    assign mode_ctrl.pulse_out_two_off = mode_one_ff[`EMCR_BIT_P2_OFF];
    assign mode_ctrl.pulse_out_one_off = mode_one_ff[`EMCR_BIT_P1_OFF];
    assign mode_ctrl.highpass_off = mode_one_ff[`EMCR_BIT_HIGHPASS_OFF];

    assign cal_ctrl.second_current_match_gain = i2_gain_ff;
    assign cal_ctrl.active_power_gain = w_gain_ff;
    assign cal_ctrl.reactive_power_gain = var_gain_ff;
    assign cal_ctrl.apparent_power_gain = va_gain_ff;
    assign cal_ctrl.active_power_offset = w_ofs_ff;
    assign cal_ctrl.reactive_power_offset = var_ofs_ff;
    assign cal_ctrl.current_rms_offset = irms_ofs_ff;
    assign cal_ctrl.voltage_rms_offset = vrms_ofs_ff;
    assign cal_ctrl.active_energy_scale = w_scale_ff;
    assign cal_ctrl.reactive_energy_scale = var_scale_ff;
    assign cal_ctrl.apparent_energy_scale = va_scale_ff;
    assign cal_ctrl.pulse_out_one_numerator = p1_num_ff;
    assign cal_ctrl.pulse_out_one_denominator = p1_den_ff;
    assign cal_ctrl.pulse_out_two_numerator = p2_num_ff;
    assign cal_ctrl.pulse_out_two_denominator = p2_den_ff;
    assign cal_ctrl.zero_cross_output_mode = zx_mode_ff;
    assign cal_ctrl.calibration_mode = cal_mode_ff;

endmodule

// ### tb/emcr_regs_monitor.sv
// Concurrent checks on the calibration register bank ports
`timescale 1ns/1ns
`include "emcr_map.svh"

module emcr_regs_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire emcr_pkg::emcr_mode_type mode_ctrl,
    input wire emcr_pkg::emcr_cal_type cal_ctrl,
    input wire logic soft_reset_busy
);
    // ----------------------------------------------------------------
    // Data-phase tracking
    // ----------------------------------------------------------------
    logic tk_ff;
    logic wr_ff;
    logic [6:0] idx_ff;
    wire taken = hsel & hready & htrans[1] & hreadyout;
    wire dp = tk_ff & hreadyout;
    wire mode_wr = dp & wr_ff & (idx_ff == `EMCR_IDX_MODE_ONE);
    wire mode_rd = dp & !wr_ff & (idx_ff == `EMCR_IDX_MODE_ONE);
    wire den_wr = dp & wr_ff & (idx_ff == `EMCR_IDX_P1_DEN);
    wire gain_wr = dp & wr_ff & (idx_ff == `EMCR_IDX_W_GAIN);

    // Only advance on completed beats so the sweep stall keeps the phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tk_ff <= 1'b0;
            wr_ff <= 1'b0;
            idx_ff <= 7'h00;
        end else if (hreadyout) begin
            tk_ff <= taken;
            wr_ff <= hwrite;
            idx_ff <= haddr[8:2];
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    srst_start_a: assert property (
        mode_wr && hwdata[7] |=> soft_reset_busy ##1 !soft_reset_busy)
        else $error("soft reset sweep missing or too long");
    srst_discard_a: assert property (
        mode_wr && hwdata[7] |=> $stable(mode_ctrl))
        else $error("soft reset write changed mode controls");
    srst_defaults_a: assert property (
        soft_reset_busy |=> mode_ctrl == 7'h06 && cal_ctrl.active_power_gain == 12'h000
            && cal_ctrl.pulse_out_two_denominator == 16'h003f)
        else $error("defaults not restored by soft reset");
    mode_load_a: assert property (
        mode_wr && !hwdata[7] |=> mode_ctrl == $past(hwdata[6:0]))
        else $error("mode controls do not follow written bits");
    mode_hold_a: assert property (
        !mode_wr && !soft_reset_busy |=> $stable(mode_ctrl))
        else $error("mode controls changed without a write");
    busy_ready_a: assert property (
        soft_reset_busy == !hreadyout)
        else $error("busy and ready disagree");
    den_load_a: assert property (
        den_wr |=> cal_ctrl.pulse_out_one_denominator == $past(hwdata[15:0]))
        else $error("denominator not loaded");
    gain_load_a: assert property (
        gain_wr |=> cal_ctrl.active_power_gain == $past(hwdata[11:0]))
        else $error("power gain not loaded");
    mode_read_a: assert property (
        mode_rd |-> hrdata == {25'h000_0000, mode_ctrl})
        else $error("mode readback differs from controls");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("error response seen");

    cover property (mode_wr && hwdata[7]);
    cover property (den_wr);
    cover property (soft_reset_busy ##1 taken);
endmodule

bind emcr_regs emcr_regs_monitor emcr_regs_monitor_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mode_ctrl(mode_ctrl), .cal_ctrl(cal_ctrl),
    .soft_reset_busy(soft_reset_busy)
);

// ### tb/emcr_regs_tb_top.sv
// Self-checking bench for the calibration register bank
`timescale 1ns/1ns

module emcr_regs_tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic soft_reset_busy;
    emcr_pkg::emcr_mode_type mode_ctrl;
    emcr_pkg::emcr_cal_type cal_ctrl;
    logic rdy_n;
    logic [31:0] rd_n;
    logic [31:0] rd;
    logic [31:0] d;
    logic [31:0] st = 32'd13607;
    int n_fail = 0;
    int checks = 0;
    localparam logic [6:0] REGS [19] = '{7'h0b, 7'h1c, 7'h1d, 7'h1e, 7'h1f, 7'h20, 7'h21,
        7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h28, 7'h29, 7'h2a, 7'h2b, 7'h3d, 7'h3c};

    emcr_regs emcr_regs_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mode_ctrl(mode_ctrl),
        .cal_ctrl(cal_ctrl), .soft_reset_busy(soft_reset_busy)
    );

    initial begin
        forever #4 hclk = ~hclk;
    end

    // Sampled mid-cycle, so the edge never races the bus outputs
    always @(negedge hclk) begin
        rdy_n = hreadyout;
        rd_n = hrdata;
    end

    function automatic logic [31:0] rnd();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st;
    endfunction

    // Readable bits; mode bit 7 is never stored
    function automatic logic [31:0] msk(input logic [6:0] i);
        case (i)
            7'h0b: return 32'h0000_007f;
            7'h24, 7'h25, 7'h26, 7'h2b, 7'h3d: return 32'h0000_00ff;
            7'h1c, 7'h1d, 7'h1e, 7'h1f, 7'h22, 7'h23: return 32'h0000_0fff;
            7'h20, 7'h21, 7'h27, 7'h28, 7'h29, 7'h2a, 7'h3c: return 32'h0000_ffff;
            default: return 32'h0000_0000;
        endcase
    endfunction

    function automatic logic [31:0] rstv(input logic [6:0] i);
        case (i)
            7'h0b: return 32'h0000_0006;
            7'h28, 7'h2a: return 32'h0000_003f;
            7'h3c: return 32'h0000_0300;
            default: return 32'h0000_0000;
        endcase
    endfunction

    // Datapath copy of a register, zero-extended like the readback
    function automatic logic [31:0] cal_of(input logic [6:0] i);
        case (i)
            7'h0b: return 32'(mode_ctrl);
            7'h1c: return 32'(cal_ctrl.second_current_match_gain);
            7'h1d: return 32'(cal_ctrl.active_power_gain);
            7'h1e: return 32'(cal_ctrl.reactive_power_gain);
            7'h1f: return 32'(cal_ctrl.apparent_power_gain);
            7'h20: return 32'(cal_ctrl.active_power_offset);
            7'h21: return 32'(cal_ctrl.reactive_power_offset);
            7'h22: return 32'(cal_ctrl.current_rms_offset);
            7'h23: return 32'(cal_ctrl.voltage_rms_offset);
            7'h24: return 32'(cal_ctrl.active_energy_scale);
            7'h25: return 32'(cal_ctrl.reactive_energy_scale);
            7'h26: return 32'(cal_ctrl.apparent_energy_scale);
            7'h27: return 32'(cal_ctrl.pulse_out_one_numerator);
            7'h28: return 32'(cal_ctrl.pulse_out_one_denominator);
            7'h29: return 32'(cal_ctrl.pulse_out_two_numerator);
            7'h2a: return 32'(cal_ctrl.pulse_out_two_denominator);
            7'h2b: return 32'(cal_ctrl.zero_cross_output_mode);
            7'h3d: return 32'(cal_ctrl.calibration_mode);
            default: return 32'h0000_0000;
        endcase
    endfunction

    task automatic print_verdict();
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single AHB transfer; entered and left right after a rising edge
    task automatic xfer(input logic wr, input logic [6:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {23'h00_0000, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'b10;
        do begin @(posedge hclk); n++; end while (!rdy_n && n < 64);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge hclk); n++; end while (!rdy_n && n < 64);
        rd = rd_n;
        if (n >= 64) begin
            n_fail++;
            $display("ERROR %0t: bus wait ran out", $time);
            print_verdict();
        end
    endtask

    task automatic read_all_defaults();
        foreach (REGS[k]) begin
            xfer(1'b0, REGS[k], rnd());
            chk(rd, rstv(REGS[k]));
            if (REGS[k] != 7'h3c) chk(cal_of(REGS[k]), rstv(REGS[k]));
        end
    endtask

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({25'h000_0000, mode_ctrl}, 32'h0000_0006);
        read_all_defaults();
        // Back-to-back write then read; first round all ones shows no sign extension
        for (int r = 0; r < 3; r++) begin
            for (int k = 1; k < 18; k++) begin
                d = (r == 0) ? 32'hffff_ffff : rnd();
                xfer(1'b1, REGS[k], d);
                xfer(1'b0, REGS[k], rnd());
                chk(rd, d & msk(REGS[k]));
                chk(cal_of(REGS[k]), d & msk(REGS[k]));
            end
        end
        chk({24'h00_0000, cal_ctrl.calibration_mode}, d & 32'h0000_00ff);
        xfer(1'b1, 7'h00, 32'h0000_5a5a);
        xfer(1'b0, 7'h00, rnd());
        chk(rd, 32'h0000_0000);
        // Each mode control alone
        for (int b = 0; b < 7; b++) begin
            xfer(1'b1, 7'h0b, 32'h0000_0001 << b);
            #1;
            chk({25'h000_0000, mode_ctrl}, 32'h0000_0001 << b);
            @(posedge hclk);
            xfer(1'b0, 7'h0b, rnd());
            chk(rd, 32'h0000_0001 << b);
        end
        // Soft reset, then a read that must ride out the sweep stall
        xfer(1'b1, 7'h0b, 32'h0000_00ff);
        xfer(1'b0, 7'h0b, rnd());
        chk(rd, 32'h0000_0006);
        chk({25'h000_0000, mode_ctrl}, 32'h0000_0006);
        read_all_defaults();
        print_verdict();
    end
endmodule
